// ===== bench/can_bit_stuffing_frame_logic_tb.sv
`default_nettype none
module can_bit_stuffing_frame_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst = 1'b1;
    logic dBit = 1'b1, dStuf = 1'b0, sendFlag = 1'b0, last = 1'b1, flagMode = 1'b0;
    logic seenErr = 1'b0;
    logic dataTake, dataValid, rxBit, stuffErr;
    int err_count = 0, cmp_count = 0, cyc = 0, stuffs = 0, bits = 0, wire_n = 0, run = 0;
    int domRun = 0;
    logic [1:0] stimQ[$];
    logic expQ[$];
    logic [31:0] lfsr = 32'hCD94;
    always #4 ref_clk = ~ref_clk;
    cbs_link_if link ();
    cbs_tx i_cbs_tx (.ref_clk(ref_clk), .rst(rst), .dataBit(dBit), .dataStuffed(dStuf),
        .sendErrFlag(sendFlag), .dataTake(dataTake), .link(link));
    cbs_rx i_cbs_rx (.ref_clk(ref_clk), .rst(rst), .link(link), .dataValid(dataValid),
        .dataBit(rxBit), .stuffErr(stuffErr));
    cbs_checker i_cbs_checker (.ref_clk(ref_clk), .rst(rst), .bitEn(link.bitEn),
        .canBit(link.canBit), .stuffed(link.stuffed));
    function automatic logic [31:0] step(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : step
    task automatic check(string what, logic exp, logic got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : check
    task automatic give_verdict();
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    always @(negedge ref_clk) begin
        cyc++;
        if (cyc > 4000) begin
            err_count++;
            give_verdict();
        end
        if (link.bitEn === 1'b1) wire_n++;
        if (flagMode && link.bitEn === 1'b1) begin
            sendFlag = 1'b0;
            domRun += (link.canBit === 1'b0);
        end
        if (dataTake === 1'b1 && !flagMode) begin
            expQ.push_back(dBit);
            bits++;
            check("wire bit count", 1'b1, wire_n == bits + stuffs);
            // sender run model: unstuffed fields clear it, a stuff bit restarts it at one
            run = !dStuf ? 0 : (dBit == last) ? run + 1 : 1;
            last = dBit;
            if (run == 5) begin
                stuffs++;
                last = ~dBit;
                run = 1;
            end
            {dStuf, dBit} = stimQ.size() ? stimQ.pop_front() : 2'b01;
        end
    end
    // watcher: takes the oldest expected bit whenever the receiver hands one over outside flag mode
    always @(negedge ref_clk) begin
        if (dataValid === 1'b1 && !flagMode) check("rx bit", expQ.pop_front(), rxBit);
        if (!flagMode) check("stuff error", 1'b0, stuffErr);
        if (stuffErr === 1'b1) seenErr = 1'b1;
    end
    initial begin
        for (int i = 0; i < 10; i++) stimQ.push_back(2'b11);
        for (int i = 0; i < 6; i++) stimQ.push_back(2'b10);
        for (int i = 0; i < 7; i++) stimQ.push_back(2'b01);
        for (int i = 0; i < 40; i++) begin
            lfsr = step(lfsr);
            stimQ.push_back({1'b1, lfsr[0]});
        end
        {dStuf, dBit} = stimQ.pop_front();
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        wait (stimQ.size() == 0);
        repeat (40) @(negedge ref_clk);
        flagMode = 1'b1;
        sendFlag = 1'b1;
        repeat (200) @(negedge ref_clk);
        check("flag error", 1'b1, seenErr);
        check("flag length", 1'b1, domRun == 6);
        give_verdict();
    end
endmodule : can_bit_stuffing_frame_logic_tb
`default_nettype wire

// ===== bench/cbs_checker.sv
`default_nettype none
module cbs_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic bitEn,
    input wire logic canBit,
    input wire logic stuffed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] runR, runNxt;
    logic lastR, lastNxt;
    always_comb begin
        runNxt = runR;
        lastNxt = lastR;
        if (bitEn) begin
            lastNxt = canBit;
            runNxt = !stuffed ? 4'h0 : (canBit == lastR) ? runR + 4'h1 : 4'h1;
        end
    end
    always_ff @(posedge ref_clk) begin
        runR <= rst ? 4'h0 : runNxt;
        lastR <= rst ? 1'b1 : lastNxt;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_bit_period: assert property (bitEn |-> ##16 bitEn) else $error("bit period");
    a_gap_quiet: assert property (bitEn |=> !bitEn [*8]) else $error("early bit");
    a_gap_rest: assert property (bitEn |-> ##9 !bitEn [*6]) else $error("early bit");
    a_level_holds: assert property (!bitEn |-> $stable(canBit)) else $error("level moved");
    a_field_holds: assert property (!bitEn |-> $stable(stuffed)) else $error("field moved");
    // the flag breaks dominant runs on purpose, so only recessive runs are bounded
    a_ones_bounded: assert property (
        bitEn && stuffed && canBit && lastR |-> runR < 4'h5) else $error("six ones");
    a_reset_idle: assert property ($fell(rst) |-> canBit && !bitEn && !stuffed)
        else $error("not idle");
    a_first_bit: assert property ($fell(rst) |-> !bitEn [*8]) else $error("first bit early");
    cover property (bitEn && stuffed && runR == 4'h5);
    cover property (bitEn && !stuffed && canBit);
    cover property (bitEn && stuffed && !canBit && !lastR && runR == 4'h4);
endmodule : cbs_checker
`default_nettype wire

// ===== src/cbs_link_if.sv
`default_nettype none
interface cbs_link_if;
    logic bitEn;
    logic canBit;
    logic stuffed;
    modport tx (output bitEn, output canBit, output stuffed);
    modport rx (input bitEn, input canBit, input stuffed);
endinterface : cbs_link_if
`default_nettype wire

// ===== src/cbs_pkg.sv
`default_nettype none
package cbs_pkg;
    localparam int unsigned RUN_LIMIT = 5;
    localparam int unsigned ERR_RUN = 6;
    localparam int unsigned ERR_FLAG_LEN = 6;
    localparam int unsigned ID_W = 11;
    localparam int unsigned BIT_DIV = 16;
    localparam int unsigned DIV_W = 4;
    localparam logic [DIV_W-1:0] DIV_LAST = 4'(BIT_DIV - 1);
    localparam logic [2:0] RUN_ONE = 3'h1;
    localparam logic [2:0] RUN_STUFF = 3'(RUN_LIMIT);
    localparam logic [2:0] RUN_ERR = 3'(ERR_RUN);
    localparam logic [2:0] FLAG_LAST = 3'(ERR_FLAG_LEN - 1);
    localparam logic DOMINANT = 1'b0;
    localparam logic RECESSIVE = 1'b1;
endpackage : cbs_pkg
`default_nettype wire

// ===== src/cbs_rx.sv
`default_nettype none
module cbs_rx
    import cbs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    cbs_link_if.rx link,
    output logic dataValid,
    output logic dataBit,
    output logic stuffErr
);
    import cbs_pkg::*;
    logic dataValid_r, dataValid_nxt;
    logic dataBit_r, dataBit_nxt;
    logic stuffErr_r, stuffErr_nxt;
    logic lastBit_r, lastBit_nxt;
    logic [2:0] run_r, run_nxt;
    logic dropNext_r, dropNext_nxt;

    always_comb begin
        dataValid_nxt = 1'b0;
        dataBit_nxt = dataBit_r;
        stuffErr_nxt = 1'b0;
        lastBit_nxt = lastBit_r;
        run_nxt = run_r;
        dropNext_nxt = dropNext_r;
        if (link.bitEn) begin
            lastBit_nxt = link.canBit;
            if (!link.stuffed) begin
                // fixed fields pass untouched and clear run tracking, as the sender does
                run_nxt = 3'h0;
                dropNext_nxt = 1'b0;
                dataValid_nxt = 1'b1;
                dataBit_nxt = link.canBit;
            end else begin
                if (link.canBit == lastBit_r && run_r != 3'h0) begin
                    run_nxt = (run_r == RUN_ERR) ? RUN_ERR : run_r + 3'h1;
                end else begin
                    run_nxt = RUN_ONE;
                end
                if (link.canBit == lastBit_r && run_r == RUN_STUFF) begin
                    stuffErr_nxt = 1'b1; // sixth equal bit
                    dropNext_nxt = 1'b0;
                end else if (dropNext_r) begin
                    dropNext_nxt = 1'b0; // stuff bit removed, starts new run
                end else begin
                    dataValid_nxt = 1'b1;
                    dataBit_nxt = link.canBit;
                end
                if (run_nxt == RUN_STUFF && !(link.canBit == lastBit_r && run_r == RUN_STUFF)) begin
                    dropNext_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dataValid_r <= 1'b0;
            dataBit_r <= RECESSIVE;
            stuffErr_r <= 1'b0;
            lastBit_r <= RECESSIVE;
            run_r <= 3'h0;
            dropNext_r <= 1'b0;
        end else begin
            dataValid_r <= dataValid_nxt;
            dataBit_r <= dataBit_nxt;
            stuffErr_r <= stuffErr_nxt;
            lastBit_r <= lastBit_nxt;
            run_r <= run_nxt;
            dropNext_r <= dropNext_nxt;
        end
    end

    assign dataValid = dataValid_r;
    assign dataBit = dataBit_r;
    assign stuffErr = stuffErr_r;
endmodule : cbs_rx
`default_nettype wire

// ===== src/cbs_tx.sv
`default_nettype none
// Contract
// - insert opposite bit after five equal bits
// - receiver removes every stuff bit
// - CRC delimiter, ACK, EOF not stuffed
// - six equal stuffed bits is error
// - error flag is six dominant bits
// - standard frames with 11-bit identifiers
module cbs_tx
    import cbs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic dataBit,
    input wire logic dataStuffed,
    input wire logic sendErrFlag,
    output logic dataTake,
    cbs_link_if.tx link
);
    import cbs_pkg::*;
    // frame content (11-bit identifier, standard format) is built upstream
    typedef enum logic [1:0] {
        ST_DATA = 2'b00,
        ST_STUFF = 2'b01,
        ST_FLAG = 2'b10
    } cbs_state_t;

    cbs_state_t state_r, state_nxt;
    logic [DIV_W-1:0] div_r, div_nxt;
    logic bitEn_r, bitEn_nxt;
    logic canBit_r, canBit_nxt;
    logic stuffed_r, stuffed_nxt;
    logic take_r, take_nxt;
    logic [2:0] run_r, run_nxt;
    logic [2:0] flagCnt_r, flagCnt_nxt;

    always_comb begin
        div_nxt = (div_r == DIV_LAST) ? '0 : div_r + 1'b1;
        bitEn_nxt = (div_r == DIV_LAST);
        state_nxt = state_r;
        canBit_nxt = canBit_r;
        stuffed_nxt = stuffed_r;
        take_nxt = 1'b0;
        run_nxt = run_r;
        flagCnt_nxt = flagCnt_r;
        if (div_r == DIV_LAST) begin
            unique case (state_r)
                ST_DATA: begin
                    if (sendErrFlag) begin
                        // flag breaks stuffing on purpose
                        state_nxt = ST_FLAG;
                        canBit_nxt = DOMINANT;
                        stuffed_nxt = 1'b1;
                        flagCnt_nxt = 3'h0;
                        run_nxt = 3'h0;
                    end else begin
                        take_nxt = 1'b1;
                        canBit_nxt = dataBit;
                        stuffed_nxt = dataStuffed;
                        if (!dataStuffed) begin
                            run_nxt = 3'h0;
                        end else if (dataBit == canBit_r && run_r != 3'h0) begin
                            run_nxt = run_r + 3'h1;
                        end else begin
                            run_nxt = RUN_ONE;
                        end
                        if (dataStuffed && run_nxt == RUN_STUFF) begin
                            state_nxt = ST_STUFF;
                        end
                    end
                end
                ST_STUFF: begin
                    canBit_nxt = ~canBit_r;
                    stuffed_nxt = 1'b1;
                    run_nxt = RUN_ONE;
                    state_nxt = ST_DATA;
                end
                ST_FLAG: begin
                    if (flagCnt_r == FLAG_LAST - 3'h1) begin
                        state_nxt = ST_DATA;
                    end
                    flagCnt_nxt = flagCnt_r + 3'h1;
                    canBit_nxt = DOMINANT;
                end
                default: state_nxt = ST_DATA;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_DATA;
            div_r <= '0;
            bitEn_r <= 1'b0;
            canBit_r <= RECESSIVE;
            stuffed_r <= 1'b0;
            take_r <= 1'b0;
            run_r <= 3'h0;
            flagCnt_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            div_r <= div_nxt;
            bitEn_r <= bitEn_nxt;
            canBit_r <= canBit_nxt;
            stuffed_r <= stuffed_nxt;
            take_r <= take_nxt;
            run_r <= run_nxt;
            flagCnt_r <= flagCnt_nxt;
        end
    end

    assign dataTake = take_r;
    assign link.bitEn = bitEn_r;
    assign link.canBit = canBit_r;
    assign link.stuffed = stuffed_r;
endmodule : cbs_tx
`default_nettype wire
